// [lcs_pkg.sv]
// Shared constants, types and timing counts of the status read block
package lcs_pkg;
   // -----------------------------------------------------------------
   // Status byte layout
   // -----------------------------------------------------------------
   localparam int unsigned LCS_BIT_BUSY = 7;
   localparam int unsigned LCS_BIT_MAP = 6;
   localparam int unsigned LCS_BIT_OFF = 5;
   localparam int unsigned LCS_BIT_RST = 4;
   localparam logic [3:0] LCS_LOW_NIBBLE = 4'h0;

   // -----------------------------------------------------------------
   // Command codes and column range
   // -----------------------------------------------------------------
   localparam logic [7:0] LCS_CMD_MAP_NORMAL = 8'ha0;
   localparam logic [7:0] LCS_CMD_MAP_REVERSE = 8'ha1;
   localparam logic [7:0] LCS_CMD_DISP_OFF = 8'hae;
   localparam logic [7:0] LCS_CMD_DISP_ON = 8'haf;
   localparam logic [7:0] LCS_CMD_SOFT_RESET = 8'he2;
   localparam logic [6:0] LCS_COL_LAST = 7'h4f;
   localparam logic [6:0] LCS_COL_RESET = 7'h00;
   localparam logic LCS_MAP_RESET = 1'b0;
   localparam logic LCS_DISP_ON_RESET = 1'b0;

   // -----------------------------------------------------------------
   // Timing: clock, busy time and reset time
   // -----------------------------------------------------------------
   localparam int unsigned LCS_CLK_NS = 10;
   localparam int unsigned LCS_BUSY_NS = 40;
   localparam int unsigned LCS_RESET_NS = 160;
   localparam int unsigned LCS_BUSY_CYC =
      (LCS_BUSY_NS + LCS_CLK_NS - 1) / LCS_CLK_NS;
   localparam int unsigned LCS_RESET_CYC =
      (LCS_RESET_NS + LCS_CLK_NS - 1) / LCS_CLK_NS;
   localparam int unsigned LCS_CNT_W = 8;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic cmd_data;   // 0 = command/status, 1 = display data
      logic rd_n;       // Read strobe, active low
      logic rw;         // High = read, low = write
   } lcs_ctrl_s;

   typedef struct packed {
      logic busy;
      logic map_rev;
      logic disp_off;
      logic in_reset;
   } lcs_flags_s;

   typedef enum logic [2:0] {
      LCS_ST_IDLE = 3'b001,
      LCS_ST_BUSY = 3'b010,
      LCS_ST_RESET = 3'b100
   } lcs_state_e;
endpackage

// [lcs_status_port.sv]
// Registered status byte driver for the parallel data bus
`timescale 1ns/1ps
`default_nettype none
module lcs_status_port
   import lcs_pkg::*;
(
   input wire logic clk_sys_in,             // System clock
   input wire logic rstn_in,                // Async reset, active low
   input wire logic read_sel_in,            // Status read selected
   input wire lcs_pkg::lcs_flags_s flags_in, // Live controller flags
   output logic [7:0] data_out,             // Data bus drive value
   output logic data_oe_out                 // Data bus drive enable
);
   logic [7:0] data_reg;
   logic [7:0] data_next;
   logic oe_reg;
   logic oe_next;

   // Assemble the byte; low nibble held at zero
   always_comb begin
      data_next = data_reg;
      oe_next = read_sel_in;
      if (read_sel_in) begin
         data_next = {flags_in.busy, flags_in.map_rev,
                      flags_in.disp_off, flags_in.in_reset,
                      LCS_LOW_NIBBLE};
      end
   end

   // Byte is refreshed every cycle while selected, so busy tracks live
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         data_reg <= 8'h00;
         oe_reg <= 1'b0;
      end else begin
         data_reg <= data_next;
         oe_reg <= oe_next;
      end
   end

   assign data_out = data_reg;
   assign data_oe_out = oe_reg;
endmodule
`default_nettype wire

// [lcs_controller.sv]
// Command front end and status flags of the LCD driver controller
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Status low nibble always reads zero
// - Bit seven busy during command or reset
// - Bit six mirrors column/segment orientation setting
// - Bit five one when display is off
// - Bit four one during reset sequence
module lcs_controller
   import lcs_pkg::*;
#(
   parameter int unsigned BUSY_CYC = LCS_BUSY_CYC,
   parameter int unsigned RESET_CYC = LCS_RESET_CYC
) (
   input wire logic clk_sys_in,        // System clock, 100 MHz
   input wire logic rstn_in,           // Async reset, active low
   input wire logic cmd_data_in,       // Command/data select pin
   input wire logic rd_n_in,           // Read strobe pin, active low
   input wire logic rw_in,             // Read/write select pin
   input wire logic [7:0] data_in,     // Data bus input level
   output logic [7:0] data_out,        // Data bus drive value
   output logic data_oe_out,           // Data bus drive enable
   output logic [6:0] col_addr_out,    // Column address pointer
   output logic segment_output_zero_src_out, // 1: seg 0 from last column
   output logic display_on_out,        // Display enabled
   output logic busy_out,              // Busy flag
   output logic in_reset_out           // Reset sequence running
);
   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   lcs_ctrl_s ctrl_meta_reg;
   lcs_ctrl_s ctrl_sync_reg;
   lcs_ctrl_s ctrl_prev_reg;
   logic [7:0] data_meta_reg;
   logic [7:0] data_sync_reg;
   lcs_ctrl_s ctrl_pin;

   assign ctrl_pin = '{cmd_data: cmd_data_in, rd_n: rd_n_in, rw: rw_in};

   // Reset values equal the idle pin levels (strobe and read select
   // high), so the edge logic sees no write ending just after reset
   // Two stages; the second stage and its one-cycle-delayed copy feed decode and edge logic
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl_meta_reg <= '{cmd_data: 1'b0, rd_n: 1'b1, rw: 1'b1};
         ctrl_sync_reg <= '{cmd_data: 1'b0, rd_n: 1'b1, rw: 1'b1};
         ctrl_prev_reg <= '{cmd_data: 1'b0, rd_n: 1'b1, rw: 1'b1};
         data_meta_reg <= 8'h00;
         data_sync_reg <= 8'h00;
      end else begin
         ctrl_meta_reg <= ctrl_pin;
         ctrl_sync_reg <= ctrl_meta_reg;
         ctrl_prev_reg <= ctrl_sync_reg;
         data_meta_reg <= data_in;
         data_sync_reg <= data_meta_reg;
      end
   end

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   // is_write serves both the current and the previous sample, is_status_read
   // the current one only, so the read select and the write edge test can never disagree
   function automatic logic is_status_read(input lcs_ctrl_s c);
      is_status_read = !c.cmd_data && !c.rd_n && c.rw;
   endfunction

   function automatic logic is_write(input lcs_ctrl_s c);
      is_write = c.rd_n && !c.rw;
   endfunction

   logic status_sel;
   logic write_end;

   // Write completes on the trailing edge of the write phase
   // Taking it at the end gives the data bus the whole write phase
   // to settle, at the price of two cycles of synchroniser delay
   assign status_sel = is_status_read(ctrl_sync_reg);
   assign write_end = is_write(ctrl_prev_reg) && !is_write(ctrl_sync_reg);

   // -----------------------------------------------------------------
   // Controller state, busy timing and settings
   // -----------------------------------------------------------------
   lcs_state_e state_reg;
   lcs_state_e state_next;
   logic [LCS_CNT_W-1:0] cnt_reg;
   logic [LCS_CNT_W-1:0] cnt_next;
   logic [6:0] col_reg;
   logic [6:0] col_next;
   logic map_reg;
   logic map_next;
   logic disp_on_reg;
   logic disp_on_next;
   logic cmd_take;
   logic [7:0] cmd_byte;
   logic cmd_is_data;

   // Latch the write phase's cmd/data level before it ends
   // The previous sample still holds the select level of the write
   assign cmd_is_data = ctrl_prev_reg.cmd_data;
   assign cmd_byte = data_sync_reg;
   // Writes during busy or reset are dropped, not queued
   // Limitation: a host that ignores busy loses its write silently;
   // no error flag is kept, so polling the status byte is the cure
   assign cmd_take = write_end && (state_reg == LCS_ST_IDLE);

   // Next-state logic; a status read enters no branch here
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      col_next = col_reg;
      map_next = map_reg;
      disp_on_next = disp_on_reg;
      unique case (state_reg)
         LCS_ST_IDLE: begin
            if (cmd_take) begin
               state_next = LCS_ST_BUSY;
               cnt_next = LCS_CNT_W'(BUSY_CYC - 1);
               if (cmd_is_data) begin
                  // Data write advances the column, wrapping at the end
                  col_next = (col_reg == LCS_COL_LAST) ?
                             LCS_COL_RESET : col_reg + 7'd1;
               end else if (!cmd_byte[7]) begin
                  // Column set; codes past the last column are ignored
                  if (cmd_byte[6:0] <= LCS_COL_LAST) begin
                     col_next = cmd_byte[6:0];
                  end
               end else if (cmd_byte == LCS_CMD_MAP_NORMAL ||
                            cmd_byte == LCS_CMD_MAP_REVERSE) begin
                  map_next = cmd_byte[0];
               end else if (cmd_byte == LCS_CMD_DISP_OFF ||
                            cmd_byte == LCS_CMD_DISP_ON) begin
                  disp_on_next = cmd_byte[0];
               end else if (cmd_byte == LCS_CMD_SOFT_RESET) begin
                  state_next = LCS_ST_RESET;
                  cnt_next = LCS_CNT_W'(RESET_CYC - 1);
               end
            end
         end
         LCS_ST_BUSY: begin
            // Count down; the cycle at zero still reports busy
            if (cnt_reg == '0) begin
               state_next = LCS_ST_IDLE;
            end else begin
               cnt_next = cnt_reg - LCS_CNT_W'(1);
            end
         end
         LCS_ST_RESET: begin
            // Reset restores settings from its first cycle on, holding busy meanwhile
            col_next = LCS_COL_RESET;
            map_next = LCS_MAP_RESET;
            disp_on_next = LCS_DISP_ON_RESET;
            if (cnt_reg == '0) begin
               state_next = LCS_ST_IDLE;
            end else begin
               cnt_next = cnt_reg - LCS_CNT_W'(1);
            end
         end
         default: begin
            // An illegal state code recovers through a full reset
            state_next = LCS_ST_RESET;
            cnt_next = LCS_CNT_W'(RESET_CYC - 1);
         end
      endcase
   end

   // Power-on starts inside the reset sequence
   // Settings reload here as well, so no half-done command survives
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_reg <= LCS_ST_RESET;
         cnt_reg <= LCS_CNT_W'(RESET_CYC - 1);
         col_reg <= LCS_COL_RESET;
         map_reg <= LCS_MAP_RESET;
         disp_on_reg <= LCS_DISP_ON_RESET;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         col_reg <= col_next;
         map_reg <= map_next;
         disp_on_reg <= disp_on_next;
      end
   end

   // -----------------------------------------------------------------
   // Status flags and readback
   // -----------------------------------------------------------------
   lcs_flags_s flags;

   // Flags are decoded from state, so they cannot drift away from it
   // Busy covers both command execution and reset
   always_comb begin
      flags.busy = (state_reg != LCS_ST_IDLE);
      flags.map_rev = map_reg;
      flags.disp_off = !disp_on_reg;
      flags.in_reset = (state_reg == LCS_ST_RESET);
   end

   // Port registers the byte and zero-fills its low nibble
   // A read only selects the port; nothing flows back into state
   lcs_status_port u_status_port (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rstn_in),
      .read_sel_in(status_sel),
      .flags_in(flags),
      .data_out(data_out),
      .data_oe_out(data_oe_out)
   );

   // Settings and flags leave straight from registered state
   assign col_addr_out = col_reg;
   assign segment_output_zero_src_out = map_reg;
   assign display_on_out = disp_on_reg;
   assign busy_out = flags.busy;
   assign in_reset_out = flags.in_reset;
endmodule
`default_nettype wire

// [lcs_props.sv]
// Port checks of the status read block
`timescale 1ns/1ps
`default_nettype none
module lcs_props
#(
   parameter int unsigned BUSY_CYC = 4,
   parameter int unsigned RESET_CYC = 16
) (
   input wire logic clk_sys_in,     // Clock
   input wire logic rstn_in,        // Reset
   input wire logic [7:0] data_out, // Status byte
   input wire logic data_oe_out,    // Bus enable
   input wire logic [6:0] col_addr_out, // Column
   input wire logic segment_output_zero_src_out, // Orientation
   input wire logic display_on_out, // Display on
   input wire logic busy_out,       // Busy
   input wire logic in_reset_out    // In reset
);
   localparam int BC1 = BUSY_CYC - 1;
   localparam int RC1 = RESET_CYC - 1;
   // ----------------------------------------------------------
   // Status byte contents
   // ----------------------------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   property p_low;
      data_oe_out |-> data_out[3:0] == 4'h0;
   endproperty
   a_low: assert property (p_low) else $error("low nibble");
   property p_busy;
      data_oe_out |-> data_out[7] == $past(busy_out);
   endproperty
   a_busy: assert property (p_busy) else $error("bit 7");
   property p_map;
      data_oe_out |-> data_out[6] == $past(segment_output_zero_src_out);
   endproperty
   a_map: assert property (p_map) else $error("bit 6");
   property p_off;
      data_oe_out |-> data_out[5] == !$past(display_on_out);
   endproperty
   a_off: assert property (p_off) else $error("bit 5");
   property p_rst;
      data_oe_out |-> data_out[4] == $past(in_reset_out);
   endproperty
   a_rst: assert property (p_rst) else $error("bit 4");
   // ----------------------------------------------------------
   // Flag timing and side effects
   // ----------------------------------------------------------
   // Reset sequence length counted from the first edge after release
   property p_rlen;
      $rose(rstn_in) |-> ##RC1 (in_reset_out && busy_out) ##1 !in_reset_out;
   endproperty
   a_rlen: assert property (p_rlen) else $error("reset len");
   property p_blen;
      $rose(busy_out) && !in_reset_out |-> ##BC1 busy_out ##1 !busy_out;
   endproperty
   a_blen: assert property (p_blen) else $error("busy len");
   // A write landing as a read starts may still move settings
   property p_quiet;
      data_oe_out && $past(data_oe_out) && !$rose(busy_out) |->
         $stable(col_addr_out) && $stable(display_on_out) &&
         $stable(segment_output_zero_src_out);
   endproperty
   a_quiet: assert property (p_quiet) else $error("read effect");
   c_rev: cover property (data_oe_out && data_out[6]);
   c_rbusy: cover property (data_oe_out && data_out[4]);
   c_cmd: cover property ($rose(busy_out) && !in_reset_out);
endmodule
bind lcs_controller lcs_props #(.BUSY_CYC(BUSY_CYC),
   .RESET_CYC(RESET_CYC)) lcs_props_i (.clk_sys_in(clk_sys_in),
   .rstn_in(rstn_in), .data_out(data_out), .data_oe_out(data_oe_out),
   .col_addr_out(col_addr_out), .display_on_out(display_on_out),
   .segment_output_zero_src_out(segment_output_zero_src_out),
   .busy_out(busy_out), .in_reset_out(in_reset_out));
`default_nettype wire

// [lcs_host.sv]
// Host microcontroller model on the parallel bus
`timescale 1ns/1ps
`default_nettype none
module lcs_host (
   input wire logic clk_sys_in,     // Clock
   input wire logic [7:0] dev_d_in, // Device drive value
   input wire logic dev_oe_in,      // Device drive enable
   input wire logic busy_in,        // Device busy
   output logic cmd_data_out,       // Command/data select
   output logic rd_n_out,           // Read strobe
   output logic rw_out,             // Read/write select
   output logic [7:0] bus_out       // Resolved data bus
);
   logic oe = 1'b0;
   logic [7:0] d = 8'h00;
   logic [7:0] last = 8'h00;
   // Undriven bus shows a changing pattern, never a stale byte
   assign bus_out = dev_oe_in ? dev_d_in : (oe ? d : ~last);
   always @(posedge clk_sys_in) last <= bus_out;
   initial begin
      cmd_data_out = 1'b0;
      rd_n_out = 1'b1;
      rw_out = 1'b1;
   end
   // Bounded wait for the busy flag to clear
   task automatic idle;
      for (int n = 0; n < 64 && busy_in !== 1'b0; n++) @(negedge clk_sys_in);
   endtask
   // Write; the byte is handed over when the write phase ends
   task automatic wr(input logic cd, input logic [7:0] v, input bit w);
      @(negedge clk_sys_in);
      cmd_data_out = cd;
      rw_out = 1'b0;
      d = v;
      oe = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      rw_out = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      oe = 1'b0;
      cmd_data_out = 1'b0;
      if (w) idle();
   endtask
   // Status read: select low, strobe low, read high
   task automatic rd(output logic [7:0] v);
      @(negedge clk_sys_in);
      rd_n_out = 1'b0;
      for (int n = 0; n < 16 && dev_oe_in !== 1'b1; n++) @(negedge clk_sys_in);
      v = bus_out;
      rd_n_out = 1'b1;
      for (int n = 0; n < 16 && dev_oe_in !== 1'b0; n++) @(negedge clk_sys_in);
   endtask
endmodule
`default_nettype wire

// [lcd_controller_status_read_tb.sv]
// Testbench of the status read block
`timescale 1ns/1ps
`default_nettype none
module lcd_controller_status_read_tb;
   import lcs_pkg::*;
   logic clk_sys_in, rstn_in, cd, rd_n, rw, oe, map, on, busy, inr;
   logic [7:0] bus, drv;
   logic [6:0] col;
   int n_mismatch = 0;
   int tests_run = 0;
   // Long busy and reset let reads land inside a command and a reset
   lcs_controller #(.BUSY_CYC(8), .RESET_CYC(24)) lcs_controller_i (
      .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .cmd_data_in(cd),
      .rd_n_in(rd_n), .rw_in(rw), .data_in(bus), .data_out(drv),
      .data_oe_out(oe), .col_addr_out(col),
      .segment_output_zero_src_out(map), .display_on_out(on),
      .busy_out(busy), .in_reset_out(inr));
   lcs_host lcs_host_i (.clk_sys_in(clk_sys_in), .dev_d_in(drv),
      .dev_oe_in(oe), .busy_in(busy), .cmd_data_out(cd), .rd_n_out(rd_n),
      .rw_out(rw), .bus_out(bus));
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   task automatic report_and_stop;
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [7:0] e, x);
      tests_run++;
      if (x !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", s, e, x);
      end
   endtask
   function automatic logic [7:0] st(input logic b, m, o, r);
      return {b, m, o, r, LCS_LOW_NIBBLE};
   endfunction
   task automatic rc(input string s, input logic [7:0] k, e);
      logic [7:0] v;
      lcs_host_i.rd(v);
      chk(s, e, v & k);
   endtask
   // --------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------
   task automatic t_power_up;
      rc("rst", 8'hff, st(1, 0, 1, 1));
      lcs_host_i.idle();
      rc("idle", 8'hff, st(0, 0, 1, 0));
   endtask
   task automatic t_settings;
      lcs_host_i.wr(1'b0, LCS_CMD_MAP_REVERSE, 1'b1);
      rc("rev", 8'hff, st(0, 1, 1, 0));
      chk("map", 8'h01, {7'h0, map});
      lcs_host_i.wr(1'b0, LCS_CMD_DISP_ON, 1'b1);
      rc("rev on", 8'hff, st(0, 1, 0, 0));
      chk("on", 8'h01, {7'h0, on});
      lcs_host_i.wr(1'b0, LCS_CMD_MAP_NORMAL, 1'b1);
      rc("nrm on", 8'hff, st(0, 0, 0, 0));
      lcs_host_i.wr(1'b0, LCS_CMD_DISP_OFF, 1'b1);
      rc("nrm off", 8'hff, st(0, 0, 1, 0));
   endtask
   // Back-to-back reads leave the pointer; data writes walk it round
   task automatic t_column;
      lcs_host_i.wr(1'b0, 8'h4e, 1'b1);
      rc("rd a", 8'hff, st(0, 0, 1, 0));
      rc("rd b", 8'hff, st(0, 0, 1, 0));
      chk("col", 8'h4e, {1'b0, col});
      lcs_host_i.wr(1'b0, 8'h50, 1'b1);
      chk("col keep", 8'h4e, {1'b0, col});
      lcs_host_i.wr(1'b1, 8'h55, 1'b1);
      chk("col end", {1'b0, LCS_COL_LAST}, {1'b0, col});
      lcs_host_i.wr(1'b1, 8'haa, 1'b1);
      chk("col wrap", 8'h00, {1'b0, col});
   endtask
   // Soft reset: a write during busy is lost, a read still answers
   task automatic t_soft_reset;
      lcs_host_i.wr(1'b0, LCS_CMD_DISP_ON, 1'b0);
      rc("cmd busy", 8'hff, st(1, 0, 0, 0));
      chk("on", 8'h01, {7'h0, on});
      lcs_host_i.idle();
      lcs_host_i.wr(1'b0, 8'h12, 1'b1);
      lcs_host_i.wr(1'b0, LCS_CMD_SOFT_RESET, 1'b0);
      lcs_host_i.wr(1'b0, 8'h33, 1'b0);
      rc("soft", 8'h9f, 8'h90);
      chk("flags", 8'h03, {6'h0, busy, inr});
      lcs_host_i.idle();
      rc("soft end", 8'hff, st(0, 0, 1, 0));
      chk("col drop", 8'h00, {1'b0, col});
      chk("on drop", 8'h00, {7'h0, on});
   endtask
   initial begin
      rstn_in = 1'b0;
      repeat (8) @(negedge clk_sys_in);
      rstn_in = 1'b1;
      t_power_up();
      t_settings();
      t_column();
      t_soft_reset();
      report_and_stop();
   end
   // Watchdog well past the few hundred cycles the run needs
   initial begin
      repeat (5000) @(posedge clk_sys_in);
      n_mismatch++;
      report_and_stop();
   end
endmodule
`default_nettype wire
